// ---- mnr_core.sv ----
// executor for multiply, negate and the two returns, one instruction at a
// time, each instruction cycle split into four phases of one clock each;
// assumes an apb master on core_clk and a software-loaded stack and memory
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "mnr_defines.svh"

module mnr_core import mnr_pkg::*; #(
	parameter bit HAS_MULTIPLIER = 1'b1
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire mnr_apb_req_t apb_req,
	output mnr_apb_rsp_t apb_rsp
);

	// ======================================================================
	// storage
	mnr_state_t st;
	mnr_state_t next_st;
	logic [7:0] data_mem [`MNR_MEM_DEPTH];
	logic [15:0] stack_mem [`MNR_STACK_DEPTH];

	logic mem_we;
	logic [7:0] mem_waddr;
	logic [7:0] mem_wdata;
	logic stk_we;
	logic [15:0] stk_wdata;
	logic busy;
	logic apb_wr;
	logic mapped;
	logic [31:0] rd_val;
	logic [15:0] stack_top;
	logic [`MNR_SP_W-1:0] sp_below;

	// ======================================================================
	// decode of an instruction word
	function automatic mnr_op_t decode_op(input logic [15:0] w);
		mnr_op_t o;
		o = mnr_nop_op;
		// the earliest variant has no multiplier: both multiplies fall to nop
		if (w[15:8] == `MNR_OPC_MULL && HAS_MULTIPLIER) begin
			o = mnr_multiply_literal_op;
		end else if (w[15:8] == `MNR_OPC_MULF && HAS_MULTIPLIER) begin
			o = mnr_multiply_file_op;
		end else if (w[15:9] == `MNR_OPC_NEG) begin
			o = mnr_negate_working_op;
		end else if (w == `MNR_OPC_RETI) begin
			o = mnr_interrupt_return_op;
		end else if (w[15:8] == `MNR_OPC_RETL) begin
			o = mnr_literal_return_op;
		end
		return o;
	endfunction

	assign busy = (st.phase != mnr_idle);
	assign apb_wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
	assign sp_below = st.sp - `MNR_SP_W'(1);
	assign stack_top = stack_mem[sp_below];

	// ======================================================================
	// read decode, used for read data and for the error answer
	always_comb begin
		mapped = 1'b1;
		rd_val = 32'h0000_0000;
		if (apb_req.paddr == `MNR_ADDR_INSTR) begin
			rd_val = {16'h0000, st.instr};
		end else if (apb_req.paddr == `MNR_ADDR_WORK) begin
			rd_val = {24'h00_0000, st.working_register};
		end else if (apb_req.paddr == `MNR_ADDR_PROD) begin
			rd_val = {16'h0000, st.product_high, st.product_low};
		end else if (apb_req.paddr == `MNR_ADDR_STATUS) begin
			rd_val = {22'h00_0000, HAS_MULTIPLIER, busy, 3'h0, st.flags};
		end else if (apb_req.paddr == `MNR_ADDR_PC) begin
			rd_val = {16'h0000, st.pc};
		end else if (apb_req.paddr == `MNR_ADDR_PC_LATCH) begin
			rd_val = {24'h00_0000, st.pc_high_latch};
		end else if (apb_req.paddr == `MNR_ADDR_STACK) begin
			rd_val = {12'h000, st.sp, stack_top};
		end else if (apb_req.paddr == `MNR_ADDR_MEMADR) begin
			rd_val = {24'h00_0000, st.mem_addr};
		end else if (apb_req.paddr == `MNR_ADDR_MEMDAT) begin
			rd_val = {24'h00_0000, data_mem[st.mem_addr]};
		end else begin
			mapped = 1'b0;
		end
	end

	// zero wait states: read data is caught in the setup cycle
	assign apb_rsp.prdata = st.prdata;
	assign apb_rsp.pready = 1'b1;
	assign apb_rsp.pslverr = apb_req.psel & apb_req.penable & ~mapped;

	// ======================================================================
	// next state: bus writes while idle, then the four phases of execution
	always_comb begin
		next_st = st;
		mem_we = 1'b0;
		mem_waddr = st.mem_addr;
		mem_wdata = 8'h00;
		stk_we = 1'b0;
		stk_wdata = 16'h0000;
		if (apb_req.psel & ~apb_req.penable) begin
			next_st.prdata = rd_val;
		end
		// writes during execution are dropped so the core never races software
		if (apb_wr && !busy) begin
			if (apb_req.paddr == `MNR_ADDR_INSTR) begin
				next_st.instr = apb_req.pwdata[15:0];
				next_st.phase = mnr_q1;
				next_st.second = 1'b0;
			end else if (apb_req.paddr == `MNR_ADDR_WORK) begin
				next_st.working_register = apb_req.pwdata[7:0];
			end else if (apb_req.paddr == `MNR_ADDR_STATUS) begin
				next_st.flags = apb_req.pwdata[`MNR_FLAGS_W-1:0];
			end else if (apb_req.paddr == `MNR_ADDR_PC) begin
				next_st.pc = apb_req.pwdata[15:0];
			end else if (apb_req.paddr == `MNR_ADDR_PC_LATCH) begin
				next_st.pc_high_latch = apb_req.pwdata[7:0];
			end else if (apb_req.paddr == `MNR_ADDR_STACK) begin
				stk_we = 1'b1;
				stk_wdata = apb_req.pwdata[15:0];
				next_st.sp = st.sp + `MNR_SP_W'(1);
			end else if (apb_req.paddr == `MNR_ADDR_MEMADR) begin
				next_st.mem_addr = apb_req.pwdata[7:0];
			end else if (apb_req.paddr == `MNR_ADDR_MEMDAT) begin
				mem_we = 1'b1;
				mem_wdata = apb_req.pwdata[7:0];
			end
		end
		case (st.phase)
			mnr_q1: begin
				// a second cycle is a forced nop: nothing is decoded
				if (!st.second) begin
					next_st.op = decode_op(st.instr);
				end
				next_st.phase = mnr_q2;
			end
			mnr_q2: begin
				// operand read: literal or the addressed memory byte
				if (!st.second) begin
					if (st.op == mnr_multiply_file_op) begin
						next_st.operand = data_mem[st.instr[7:0]];
					end else begin
						next_st.operand = st.instr[7:0];
					end
				end
				next_st.phase = mnr_q3;
			end
			mnr_q3: begin
				if (!st.second) begin
					if (st.op == mnr_negate_working_op) begin
						next_st.result = {8'h00, 8'(~st.working_register + 8'h01)};
					end else begin
						next_st.result = 16'(st.working_register) * 16'(st.operand);
					end
				end
				next_st.phase = mnr_q4;
			end
			mnr_q4: begin
				next_st.phase = mnr_idle;
				if (!st.second) begin
					case (st.op)
						mnr_multiply_literal_op, mnr_multiply_file_op: begin
							// flags and working register left alone
							next_st.product_high = st.result[15:8];
							next_st.product_low = st.result[7:0];
							next_st.pc = st.pc + 16'h0001;
						end
						mnr_negate_working_op: begin
							mem_we = 1'b1;
							mem_waddr = st.instr[7:0];
							mem_wdata = st.result[7:0];
							if (!st.instr[`MNR_NEG_SEL_BIT]) begin
								next_st.working_register = st.result[7:0];
							end
							// carry is set only when nothing was borrowed, w == 0
							next_st.flags[`MNR_FLAG_C] = (st.working_register == 8'h00);
							next_st.flags[`MNR_FLAG_DIGIT] = (st.working_register[3:0] == 4'h0);
							next_st.flags[`MNR_FLAG_Z] = (st.result[7:0] == 8'h00);
							next_st.flags[`MNR_FLAG_OVFL] = (st.working_register == 8'h80);
							next_st.pc = st.pc + 16'h0001;
						end
						mnr_interrupt_return_op: begin
							next_st.pc = stack_top;
							next_st.sp = sp_below;
							next_st.flags[`MNR_FLAG_GID] = 1'b0;
							next_st.second = 1'b1;
							next_st.phase = mnr_q1;
						end
						mnr_literal_return_op: begin
							next_st.working_register = st.instr[7:0];
							next_st.pc = stack_top;
							next_st.sp = sp_below;
							next_st.second = 1'b1;
							next_st.phase = mnr_q1;
						end
						default: begin
							next_st.pc = st.pc + 16'h0001;
						end
					endcase
				end else begin
					next_st.second = 1'b0;
				end
			end
			default: begin
			end
		endcase
	end

	// ======================================================================
	// state register
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st <= '{phase: mnr_idle, op: mnr_nop_op, flags: `MNR_FLAGS_RST,
				pc: `MNR_PC_RST, default: '0};
		end else begin
			st <= next_st;
		end
	end

	// memories have no reset: software loads them before use
	always_ff @(posedge core_clk) begin
		if (mem_we) begin
			data_mem[mem_waddr] <= mem_wdata;
		end
		if (stk_we) begin
			stack_mem[st.sp] <= stk_wdata;
		end
	end

	// ======================================================================
	// checks
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);

	logic is_mul;
	assign is_mul = (st.op == mnr_multiply_literal_op) ||
		(st.op == mnr_multiply_file_op);

	mul_keeps_work_a: assert property (
		st.phase == mnr_q4 && !st.second && is_mul
		|=> st.working_register == $past(st.working_register))
		else $error("multiply changed the working register");

	mulf_mem_keep_a: assert property (
		st.phase inside {mnr_q1, mnr_q2, mnr_q3, mnr_q4} && is_mul
		|-> !mem_we)
		else $error("multiply wrote data memory");

	mul_product_a: assert property (
		st.phase == mnr_q2 && !st.second && is_mul
		##1 st.phase == mnr_q3
		|=> ##1 {st.product_high, st.product_low} ==
			16'($past(st.working_register, 2)) * 16'($past(st.operand, 2)))
		else $error("product pair does not hold the product");

	mul_flags_keep_a: assert property (
		st.phase == mnr_q4 && !st.second && is_mul
		|=> st.flags == $past(st.flags))
		else $error("multiply changed a status flag");

	mul_one_cycle_a: assert property (
		st.phase == mnr_idle && apb_wr && apb_req.paddr == `MNR_ADDR_INSTR &&
		decode_op(apb_req.pwdata[15:0]) == mnr_multiply_literal_op
		|=> st.phase == mnr_q1 ##3 st.phase == mnr_q4 ##1 st.phase == mnr_idle)
		else $error("multiply did not finish in one instruction cycle");

	neg_value_a: assert property (
		st.phase == mnr_q4 && !st.second && st.op == mnr_negate_working_op
		|-> mem_we && mem_wdata == 8'(8'h00 - st.working_register)
		##1 st.flags[`MNR_FLAG_Z] == ($past(st.working_register) == 8'h00))
		else $error("negate result or zero flag wrong");

	neg_dest_a: assert property (
		st.phase == mnr_q4 && !st.second && st.op == mnr_negate_working_op &&
		st.instr[`MNR_NEG_SEL_BIT]
		|=> st.working_register == $past(st.working_register))
		else $error("negate with select set changed the working register");

	reti_pop_a: assert property (
		st.phase == mnr_q4 && !st.second && st.op == mnr_interrupt_return_op
		|=> st.pc == $past(stack_top) && st.sp == $past(sp_below) &&
			st.pc_high_latch == $past(st.pc_high_latch)
		##3 st.phase == mnr_q4 ##1 st.phase == mnr_idle)
		else $error("interrupt return pop or length wrong");

	reti_irq_on_a: assert property (
		st.phase == mnr_q4 && !st.second && st.op == mnr_interrupt_return_op
		|=> !st.flags[`MNR_FLAG_GID])
		else $error("interrupt return left interrupts disabled");

	retl_load_a: assert property (
		st.phase == mnr_q4 && !st.second && st.op == mnr_literal_return_op
		|=> st.working_register == $past(st.instr[7:0]) &&
			st.pc == $past(stack_top))
		else $error("literal return load wrong");

	retl_two_cyc_a: assert property (
		st.phase == mnr_q4 && !st.second && st.op == mnr_literal_return_op
		|=> st.second && st.pc_high_latch == $past(st.pc_high_latch)
		##3 st.phase == mnr_q4 ##1 st.phase == mnr_idle && !st.second)
		else $error("literal return not two cycles");

	// ======================================================================
	// side effects: what each instruction must and must not touch
	neg_flags_a: assert property (
		st.phase == mnr_q4 && !st.second && st.op == mnr_negate_working_op
		|=> st.flags[`MNR_FLAG_C] == $past(st.working_register == 8'h00) &&
			st.flags[`MNR_FLAG_OVFL] ==
				$past(st.working_register == 8'h80) &&
			st.flags[`MNR_FLAG_DIGIT] ==
				$past(st.working_register[3:0] == 4'h0))
		else $error("negate carry, nibble carry or overflow wrong");

	neg_both_dest_a: assert property (
		st.phase == mnr_q4 && !st.second && st.op == mnr_negate_working_op &&
		!st.instr[`MNR_NEG_SEL_BIT]
		|-> mem_we && mem_waddr == st.instr[7:0]
		##1 st.working_register == 8'(8'h00 - $past(st.working_register)))
		else $error("negate with select clear missed a destination");

	mulf_operand_a: assert property (
		st.phase == mnr_q3 && !st.second && st.op == mnr_multiply_file_op
		|-> st.operand == data_mem[st.instr[7:0]])
		else $error("file multiply read the wrong memory byte");

	mul_pc_step_a: assert property (
		st.phase == mnr_q4 && !st.second && is_mul
		|=> st.pc == 16'($past(st.pc) + 16'h0001))
		else $error("multiply did not advance by one word");

	reti_flags_keep_a: assert property (
		st.phase == mnr_q4 && !st.second && st.op == mnr_interrupt_return_op
		|=> st.flags[3:0] == $past(st.flags[3:0]))
		else $error("interrupt return touched an arithmetic flag");

	// the forced pass must be a true nop, or a return would run twice
	forced_nop_quiet_a: assert property (
		st.phase == mnr_q4 && st.second
		|=> st.pc == $past(st.pc) && st.flags == $past(st.flags) &&
			st.working_register == $past(st.working_register))
		else $error("forced idle pass changed core state");

	prod_only_mul_a: assert property (
		!(st.phase == mnr_q4 && !st.second && is_mul)
		|=> {st.product_high, st.product_low} ==
			$past({st.product_high, st.product_low}))
		else $error("product pair changed outside a multiply");

endmodule // mnr_core

// ---- mnr_defines.svh ----
// constants for the multiply, negate and return executor: register map,
// status field positions, reset values, opcode patterns and sequencing
// counts; assumes the package, the core and the bench include it
`ifndef MNR_DEFINES_SVH
`define MNR_DEFINES_SVH

// ==========================================================================
// register byte addresses on the apb bus
`define MNR_ADDR_W 8
`define MNR_ADDR_INSTR 8'h00
`define MNR_ADDR_WORK 8'h04
`define MNR_ADDR_PROD 8'h08
`define MNR_ADDR_STATUS 8'h0c
`define MNR_ADDR_PC 8'h10
`define MNR_ADDR_PC_LATCH 8'h14
`define MNR_ADDR_STACK 8'h18
`define MNR_ADDR_MEMADR 8'h1c
`define MNR_ADDR_MEMDAT 8'h20

// ==========================================================================
// status register fields
`define MNR_FLAG_C 0
`define MNR_FLAG_DIGIT 1
`define MNR_FLAG_Z 2
`define MNR_FLAG_OVFL 3
`define MNR_FLAG_GID 4
`define MNR_STAT_BUSY 8
`define MNR_STAT_MULT 9
`define MNR_FLAGS_W 5

// ==========================================================================
// reset values
`define MNR_FLAGS_RST 5'h10
`define MNR_PC_RST 16'h0000

// ==========================================================================
// opcode patterns
`define MNR_OPC_MULL 8'hbc
`define MNR_OPC_MULF 8'h34
`define MNR_OPC_NEG 7'h16
`define MNR_OPC_RETI 16'h0005
`define MNR_OPC_RETL 8'hb6
`define MNR_NEG_SEL_BIT 8

// ==========================================================================
// sequencing and storage
`define MNR_PHASES 4
`define MNR_STACK_DEPTH 16
`define MNR_SP_W 4
`define MNR_MEM_DEPTH 256

`endif

// ---- mnr_pkg.sv ----
// types shared by the executor: phases, decoded operations, apb carriers
// and the single packed state record; assumes mnr_defines.svh is reachable
package mnr_pkg;
	`include "mnr_defines.svh"

	// ======================================================================
	// instruction phases and decoded operations
	typedef enum logic [2:0] {
		mnr_idle, mnr_q1, mnr_q2, mnr_q3, mnr_q4
	} mnr_phase_t;

	typedef enum logic [2:0] {
		mnr_nop_op, mnr_multiply_literal_op, mnr_multiply_file_op,
		mnr_negate_working_op, mnr_interrupt_return_op, mnr_literal_return_op
	} mnr_op_t;

	// ======================================================================
	// apb request and answer
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [`MNR_ADDR_W-1:0] paddr;
		logic [31:0] pwdata;
	} mnr_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} mnr_apb_rsp_t;

	// ======================================================================
	// all clocked state of the core apart from the two memories
	typedef struct packed {
		mnr_phase_t phase;
		mnr_op_t op;
		logic second;
		logic [15:0] instr;
		logic [7:0] operand;
		logic [15:0] result;
		logic [7:0] working_register;
		logic [7:0] product_high;
		logic [7:0] product_low;
		logic [`MNR_FLAGS_W-1:0] flags;
		logic [15:0] pc;
		logic [7:0] pc_high_latch;
		logic [`MNR_SP_W-1:0] sp;
		logic [7:0] mem_addr;
		logic [31:0] prdata;
	} mnr_state_t;
endpackage

// ---- tb_top.sv ----
// self-checking bench for the multiply, negate and return executor
// assumes mnr_pkg and mnr_core are compiled first; apb is driven directly
`timescale 1ns/1ps
`include "mnr_defines.svh"

module tb_top;
	import mnr_pkg::*;

	// ======================================================================
	// clock, reset and two cores: full variant and earliest variant
	logic core_clk;
	logic rst_b;
	mnr_apb_req_t req [2];
	mnr_apb_rsp_t rsp [2];
	int dev;
	int fail_count;
	int cmp_count;
	int n_one;

	mnr_core u_dut (.core_clk(core_clk), .rst_b(rst_b),
		.apb_req(req[0]), .apb_rsp(rsp[0]));
	mnr_core #(.HAS_MULTIPLIER(1'b0)) u_dut_base (.core_clk(core_clk),
		.rst_b(rst_b), .apb_req(req[1]), .apb_rsp(rsp[1]));

	// 4 ns period
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	// ======================================================================
	// reporting
	task automatic conclude();
		$display("mismatches %0d of %0d compares", fail_count, cmp_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
			fail_count++;
		end
	endtask

	// ======================================================================
	// apb master; request held until pready seen high at a rising edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		int i;
		@(posedge core_clk);
		req[dev].psel <= 1'b1;
		req[dev].pwrite <= w;
		req[dev].paddr <= a;
		req[dev].pwdata <= d;
		@(posedge core_clk);
		req[dev].penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge core_clk);
			if (rsp[dev].pready === 1'b1) break;
		end
		if (i == 20) begin
			fail_count++;
			conclude();
		end
		q = rsp[dev].prdata;
		e = rsp[dev].pslverr;
		req[dev].psel <= 1'b0;
		req[dev].penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask

	task automatic rc(input string name, input logic [7:0] a,
		input logic [31:0] exp);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0, q, e);
		check(name, q, exp);
	endtask

	// polls busy; the poll count lets two-cycle ops be told from one-cycle
	task automatic exec(input logic [15:0] ins, output int n);
		logic [31:0] q;
		logic e;
		wr(`MNR_ADDR_INSTR, {16'h0, ins});
		n = 0;
		forever begin
			apb(1'b0, `MNR_ADDR_STATUS, 32'h0, q, e);
			n++;
			if (q[`MNR_STAT_BUSY] === 1'b0) break;
			if (n == 40) begin
				fail_count++;
				conclude();
			end
		end
	endtask

	// ======================================================================
	// scenarios
	task automatic t_mul_lit();
		int n;
		rc("reset status", `MNR_ADDR_STATUS, 32'h210);
		wr(`MNR_ADDR_WORK, 32'he2);
		wr(`MNR_ADDR_PC, 32'h100);
		wr(`MNR_ADDR_STATUS, 32'h0a);
		wr(`MNR_ADDR_INSTR, 32'hbc01);
		// write while busy must be dropped
		wr(`MNR_ADDR_WORK, 32'h55);
		exec(16'hb000, n_one);
		rc("mull by one", `MNR_ADDR_PROD, 32'he2);
		wr(`MNR_ADDR_STATUS, 32'h0a);
		wr(`MNR_ADDR_PC, 32'h100);
		exec(16'hbcc4, n);
		rc("mull product", `MNR_ADDR_PROD, 32'had08);
		rc("mull work", `MNR_ADDR_WORK, 32'he2);
		rc("mull flags", `MNR_ADDR_STATUS, 32'h20a);
		rc("mull pc", `MNR_ADDR_PC, 32'h101);
		check("mull cycles", n, n_one);
		wr(`MNR_ADDR_STATUS, 32'h0);
		exec(16'hbc00, n);
		rc("zero product", `MNR_ADDR_PROD, 32'h0);
		rc("zero no flag", `MNR_ADDR_STATUS, 32'h200);
	endtask

	task automatic t_mul_file();
		int n;
		wr(`MNR_ADDR_MEMADR, 32'h35);
		wr(`MNR_ADDR_MEMDAT, 32'hb5);
		wr(`MNR_ADDR_WORK, 32'hc4);
		exec(16'h3435, n);
		rc("mulf product", `MNR_ADDR_PROD, 32'h8a94);
		rc("mulf work", `MNR_ADDR_WORK, 32'hc4);
		rc("mulf mem", `MNR_ADDR_MEMDAT, 32'hb5);
		rc("mulf flags", `MNR_ADDR_STATUS, 32'h200);
	endtask

	// rows: work, select, address, expected work, memory, flags
	task automatic t_negate();
		logic [7:0] tw [3] = '{8'h3a, 8'h80, 8'h00};
		logic ts [3] = '{1'b0, 1'b1, 1'b0};
		logic [7:0] tf [3] = '{8'h40, 8'h41, 8'h42};
		logic [7:0] ew [3] = '{8'hc6, 8'h80, 8'h00};
		logic [7:0] em [3] = '{8'hc6, 8'h80, 8'h00};
		logic [7:0] ef [3] = '{8'h00, 8'h0a, 8'h07};
		int n;
		for (int i = 0; i < 3; i++) begin
			wr(`MNR_ADDR_STATUS, 32'h0);
			wr(`MNR_ADDR_MEMADR, {24'h0, tf[i]});
			wr(`MNR_ADDR_MEMDAT, 32'hab);
			wr(`MNR_ADDR_WORK, {24'h0, tw[i]});
			exec({7'h16, ts[i], tf[i]}, n);
			rc("neg work", `MNR_ADDR_WORK, {24'h0, ew[i]});
			rc("neg mem", `MNR_ADDR_MEMDAT, {24'h0, em[i]});
			rc("neg flags", `MNR_ADDR_STATUS, {24'h2, ef[i]});
			check("neg cycles", n, n_one);
		end
	endtask

	// both returns run a forced idle pass: two more status polls
	task automatic t_returns();
		int n;
		wr(`MNR_ADDR_STATUS, 32'h1f);
		wr(`MNR_ADDR_PC_LATCH, 32'h5a);
		wr(`MNR_ADDR_STACK, 32'h0abc);
		wr(`MNR_ADDR_STACK, 32'h1234);
		exec(16'h0005, n);
		rc("reti pc", `MNR_ADDR_PC, 32'h1234);
		rc("reti irq", `MNR_ADDR_STATUS, 32'h20f);
		rc("reti latch", `MNR_ADDR_PC_LATCH, 32'h5a);
		rc("reti sp", `MNR_ADDR_STACK, 32'h0001_0abc);
		check("reti cycles", n, n_one + 2);
		wr(`MNR_ADDR_STACK, 32'h0777);
		wr(`MNR_ADDR_WORK, 32'h07);
		exec(16'hb699, n);
		rc("retl work", `MNR_ADDR_WORK, 32'h99);
		rc("retl pc", `MNR_ADDR_PC, 32'h0777);
		rc("retl latch", `MNR_ADDR_PC_LATCH, 32'h5a);
		rc("retl sp", `MNR_ADDR_STACK, 32'h0001_0abc);
		check("retl cycles", n, n_one + 2);
	endtask

	task automatic t_unmapped();
		logic [31:0] q;
		logic e;
		apb(1'b0, 8'hfc, 32'h0, q, e);
		check("unmapped err", {31'h0, e}, 32'h1);
		check("unmapped data", q, 32'h0);
	endtask

	// earliest variant: multiply is a plain nop
	task automatic t_base();
		int n;
		dev = 1;
		wr(`MNR_ADDR_WORK, 32'he2);
		wr(`MNR_ADDR_PC, 32'h100);
		exec(16'hbcc4, n);
		rc("base product", `MNR_ADDR_PROD, 32'h0);
		rc("base pc", `MNR_ADDR_PC, 32'h101);
		rc("base status", `MNR_ADDR_STATUS, 32'h10);
		dev = 0;
	endtask

	// ======================================================================
	// main sequence
	initial begin
		rst_b = 1'b0;
		req[0] = '0;
		req[1] = '0;
		dev = 0;
		fail_count = 0;
		cmp_count = 0;
		n_one = 0;
		repeat (4) @(posedge core_clk);
		rst_b <= 1'b1;
		t_mul_lit();
		t_mul_file();
		t_negate();
		t_returns();
		t_unmapped();
		t_base();
		conclude();
	end
endmodule // tb_top
